//--- hw/fcsm_pkg.sv
// package for the flash command state machine: command codes, states,
// query link field layout, register map of the axi4-lite slave.
// assumes a single 40 MHz clock domain.
package fcsm_pkg;
   localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
   localparam logic [7:0] CMD_WORD_PGM = 8'h10;
   localparam logic [7:0] CMD_WORD_PGM_ALT = 8'h40;
   localparam logic [7:0] CMD_BUF_PGM = 8'he8;
   localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
   localparam logic [7:0] CMD_FACTORY_SETUP = 8'h80;
   localparam logic [7:0] CMD_CONFIRM = 8'hd0;
   localparam logic [7:0] CMD_SUSPEND = 8'hb0;
   localparam logic [7:0] CMD_READ_STATUS = 8'h70;
   localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
   localparam logic [7:0] CMD_READ_ID = 8'h90;
   localparam logic [7:0] CMD_READ_QUERY = 8'h98;
   localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;

   // axi register byte offsets
   localparam logic [7:0] REG_CMD = 8'h00;
   localparam logic [7:0] REG_STATE = 8'h04;
   localparam logic [7:0] REG_MODES = 8'h08;
   localparam logic [7:0] REG_IRQ_STATUS = 8'h0c;
   localparam logic [7:0] REG_IRQ_MASK = 8'h10;
   localparam logic [7:0] REG_DONE = 8'h14;
   localparam logic [7:0] REG_QUERY_LINK = 8'h18;
   localparam logic [7:0] REG_QUERY_QTY = 8'h1c;
   localparam logic [7:0] REG_LINK_CFG = 8'h20;
   localparam logic [7:0] REG_QTY_CFG = 8'h24;

   // query addresses
   localparam logic [11:0] QRY_EXT_BASE = 12'h10a;
   localparam logic [11:0] QRY_LINK_OFS = 12'h048;
   localparam logic [11:0] QRY_LINK_ADDR = QRY_EXT_BASE + QRY_LINK_OFS;
   localparam logic [11:0] QRY_QTY_ADDR = QRY_LINK_ADDR + 12'h004;

   // link field layout
   localparam int LINK_OFS_LSB = 0;
   localparam int LINK_OFS_W = 10;
   localparam int LINK_SEG_LSB = 10;
   localparam int LINK_SEG_W = 18;
   localparam int LINK_TYPE_LSB = 28;
   localparam int LINK_TYPE_W = 3;
   localparam int LINK_MORE_BIT = 31;
   localparam int QTY_N_LSB = 0;
   localparam int QTY_N_W = 4;
   localparam int QTY_DIE_BIT = 4;
   localparam int QTY_PLACE_BIT = 5;
   localparam logic [31:0] LINK_RESET = 32'hffffffff;
   localparam logic [7:0] QTY_RESET = 8'h3f;

   // interrupt status bits
   localparam int IRQ_DONE = 0;
   localparam int IRQ_ERR = 1;
   localparam int IRQ_LOCK_ERR = 2;
   localparam int IRQ_W = 3;

   typedef enum logic [1:0] {
      FCSM_RD_ARRAY = 2'h0,
      FCSM_RD_ID = 2'h1,
      FCSM_RD_QUERY = 2'h2,
      FCSM_RD_STATUS = 2'h3
   } fcsm_rdmode_t;

   typedef enum logic [15:0] {
      S_READY = 16'h0001,
      S_LOCK_SETUP = 16'h0002,
      S_PGM_SETUP = 16'h0004,
      S_PGM_BUSY = 16'h0008,
      S_PGM_SUSP = 16'h0010,
      S_BP_SETUP = 16'h0020,
      S_BP_BUSY = 16'h0040,
      S_BP_SUSP = 16'h0080,
      S_ERS_SETUP = 16'h0100,
      S_ERS_BUSY = 16'h0200,
      S_ERS_SUSP = 16'h0400,
      S_ES_PGM_SETUP = 16'h0800,
      S_ES_PGM_BUSY = 16'h1000,
      S_ES_PGM_SUSP = 16'h2000,
      S_ES_LOCK_SETUP = 16'h4000,
      S_FACT_SETUP = 16'h8000
   } fcsm_state_t;

   typedef struct packed {
      logic valid;
      logic [7:0] code;
      logic [1:0] part;
   } fcsm_cmd_t;

   typedef struct packed {
      logic err;
      logic lockErr;
      logic done;
   } fcsm_evt_t;

   // decode of the word program command pair
   function automatic logic fcsm_is_pgm(input logic [7:0] c);
      return (c == CMD_WORD_PGM) || (c == CMD_WORD_PGM_ALT);
   endfunction : fcsm_is_pgm
endpackage : fcsm_pkg

//--- hw/fcsm_next_state.sv
// next state logic of the command state machine.
// assumes the caller registers the state; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module fcsm_next_state
   import fcsm_pkg::*;
(
   input wire fcsm_state_t cur,
   input wire fcsm_cmd_t cmd,
   input wire logic arrayDone,
   output fcsm_state_t nxt,
   output fcsm_evt_t evt
);
   wire logic [7:0] c = cmd.code;
   wire logic isConf = cmd.valid && c == CMD_CONFIRM;
   wire logic isSusp = cmd.valid && c == CMD_SUSPEND;

   // read mode of the partition is not an input here
   always_comb begin
      nxt = cur;
      evt = '0;
      unique case (cur)
         S_READY: begin
            if (cmd.valid) begin
               if (fcsm_is_pgm(c)) nxt = S_PGM_SETUP;
               else if (c == CMD_BUF_PGM) nxt = S_BP_SETUP;
               else if (c == CMD_ERASE_SETUP) nxt = S_ERS_SETUP;
               else if (c == CMD_FACTORY_SETUP) nxt = S_FACT_SETUP;
               else if (c == CMD_LOCK_SETUP) nxt = S_LOCK_SETUP;
            end
         end
         S_LOCK_SETUP: begin
            if (cmd.valid) begin
               nxt = S_READY;
               evt.lockErr = !isConf;
               evt.done = isConf;
            end
         end
         S_ERS_SETUP: begin
            if (cmd.valid) begin
               nxt = isConf ? S_ERS_BUSY : S_READY;
               evt.err = !isConf;
            end
         end
         S_FACT_SETUP: begin
            if (cmd.valid) begin
               nxt = isConf ? S_BP_BUSY : S_READY;
               evt.err = !isConf;
            end
         end
         S_PGM_SETUP: if (cmd.valid) nxt = S_PGM_BUSY;
         S_BP_SETUP: if (cmd.valid) nxt = isConf ? S_BP_BUSY : S_READY;
         S_PGM_BUSY, S_BP_BUSY, S_ERS_BUSY: begin
            if (isSusp) begin
               nxt = cur == S_PGM_BUSY ? S_PGM_SUSP : (cur == S_BP_BUSY ? S_BP_SUSP : S_ERS_SUSP);
            end else if (arrayDone) begin
               nxt = S_READY;
               evt.done = 1'b1;
            end
         end
         S_PGM_SUSP: if (isConf) nxt = S_PGM_BUSY;
         S_BP_SUSP: if (isConf) nxt = S_BP_BUSY;
         S_ERS_SUSP: begin
            if (isConf) nxt = S_ERS_BUSY;
            else if (cmd.valid && fcsm_is_pgm(c)) nxt = S_ES_PGM_SETUP;
            else if (cmd.valid && c == CMD_LOCK_SETUP) nxt = S_ES_LOCK_SETUP;
         end
         S_ES_PGM_SETUP: if (cmd.valid) nxt = S_ES_PGM_BUSY;
         S_ES_PGM_BUSY: begin
            if (isSusp) nxt = S_ES_PGM_SUSP;
            else if (arrayDone) begin
               nxt = S_ERS_SUSP;
               evt.done = 1'b1;
            end
         end
         S_ES_PGM_SUSP: if (isConf) nxt = S_ES_PGM_BUSY;
         S_ES_LOCK_SETUP: begin
            if (cmd.valid) begin
               nxt = S_ERS_SUSP;
               evt.lockErr = !isConf;
            end
         end
         default: nxt = S_READY;
      endcase
   end
endmodule : fcsm_next_state
`default_nettype wire

//--- hw/fcsm_top.sv
// flash command state machine with axi4-lite register access.
// assumes one clock; commands and array completion come from software.
//
// The placing of the registers and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - only one partition may program or erase at once
// - each partition keeps its last read mode until changed
// - next state depends on state, command and array done only
// - word program during erase suspend nests inside the suspend
// - link field bits 0-9 hold table offset in segment
// - link field bits 10-27 hold the 32-Mbit segment index
// - link field bits 28-30 hold memory type
// - link field bit 31 set when another link follows
// - link field at query 10Ah plus 48h, four bytes
// - quantity byte follows; low nibble n, quantity n+1; bits 6-7 reserved
// - quantity bit 4 flags table versus die placement
// - quantity bit 5 flags link versus table placement
module fcsm_top
   import fcsm_pkg::*;
#(
   parameter int NUM_PARTS = 4
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic irq
);
   fcsm_state_t stateReg;
   fcsm_state_t stateNext;
   fcsm_rdmode_t modeReg [NUM_PARTS];
   logic [1:0] activePartReg;
   logic [IRQ_W-1:0] irqStatusReg;
   logic [IRQ_W-1:0] irqMaskReg;
   logic [31:0] linkReg;
   logic [7:0] qtyReg;
   logic [7:0] awAddrReg;
   logic [31:0] wDataReg;
   logic [3:0] wStrbReg;
   logic awHeldReg;
   logic wHeldReg;
   logic bValidReg;
   logic [1:0] bRespReg;
   logic rValidReg;
   logic [31:0] rDataReg;
   logic [1:0] rRespReg;
   fcsm_evt_t evt;

   // write path: address and data are latched in either order
   wire logic awTake = s_axi_awvalid && !awHeldReg && !bValidReg;
   wire logic wTake = s_axi_wvalid && !wHeldReg && !bValidReg;
   wire logic [7:0] wrAddr = awHeldReg ? awAddrReg : s_axi_awaddr;
   wire logic [31:0] wrData = wHeldReg ? wDataReg : s_axi_wdata;
   wire logic [3:0] wrStrb = wHeldReg ? wStrbReg : s_axi_wstrb;
   wire logic wrGo = (awHeldReg || awTake) && (wHeldReg || wTake);
   wire logic wrCmd = wrGo && wrAddr == REG_CMD;
   wire logic wrDone = wrGo && wrAddr == REG_DONE && wrData[0];
   wire logic wrIrqSt = wrGo && wrAddr == REG_IRQ_STATUS;
   wire logic wrMask = wrGo && wrAddr == REG_IRQ_MASK;
   wire logic wrLink = wrGo && wrAddr == REG_LINK_CFG;
   wire logic wrQty = wrGo && wrAddr == REG_QTY_CFG;
   wire logic wrKnown = wrCmd || wrAddr == REG_DONE || wrIrqSt || wrMask || wrLink || wrQty;
   wire logic fullWord = wrStrb == 4'hf;

   // command register: code in 7:0, partition in 9:8
   fcsm_cmd_t cmd;
   assign cmd.valid = wrCmd && wrStrb[0];
   assign cmd.code = wrData[7:0];
   assign cmd.part = wrData[9:8];

   wire logic opBusy = !(stateReg inside {S_READY, S_LOCK_SETUP});
   // a foreign partition may not start a new op while one is open
   wire logic foreignStart = opBusy && cmd.part != activePartReg &&
      (fcsm_is_pgm(cmd.code) || cmd.code == CMD_BUF_PGM || cmd.code == CMD_ERASE_SETUP);
   fcsm_cmd_t cmdGated;
   assign cmdGated.valid = cmd.valid && !foreignStart;
   assign cmdGated.code = cmd.code;
   assign cmdGated.part = cmd.part;

   fcsm_next_state u_next (
      .cur(stateReg),
      .cmd(cmdGated),
      .arrayDone(wrDone),
      .nxt(stateNext),
      .evt(evt)
   );

   wire logic startOp = stateReg == S_READY && stateNext != S_READY;
   wire logic [IRQ_W-1:0] irqSet = {evt.lockErr, evt.err | (cmd.valid & foreignStart), evt.done};

   always_ff @(posedge clk or posedge rst) begin
      if (rst) stateReg <= S_READY;
      else stateReg <= stateNext;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) activePartReg <= 2'h0;
      else if (startOp) activePartReg <= cmd.part;
   end

   // read mode per partition; the state machine never looks at it
   function automatic fcsm_rdmode_t mode_of(input logic [7:0] c, input fcsm_rdmode_t old);
      if (c == CMD_READ_ARRAY) return FCSM_RD_ARRAY;
      if (c == CMD_READ_ID) return FCSM_RD_ID;
      if (c == CMD_READ_QUERY) return FCSM_RD_QUERY;
      if (c == CMD_READ_STATUS) return FCSM_RD_STATUS;
      return old;
   endfunction : mode_of

   for (genvar p = 0; p < NUM_PARTS; p++) begin : g_mode
      always_ff @(posedge clk or posedge rst) begin
         if (rst) modeReg[p] <= FCSM_RD_ARRAY;
         else if (cmdGated.valid && cmd.part == 2'(p)) modeReg[p] <= mode_of(cmd.code, modeReg[p]);
      end
   end

   // sticky status, set wins over write-one-to-clear
   always_ff @(posedge clk or posedge rst) begin
      if (rst) irqStatusReg <= '0;
      else irqStatusReg <= (irqStatusReg & ~(wrIrqSt ? wrData[IRQ_W-1:0] : '0)) | irqSet;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) irqMaskReg <= '0;
      else if (wrMask) irqMaskReg <= wrData[IRQ_W-1:0];
   end

   // level irq; clear status command leaves these bits, only software w1c clears them
   assign irq = |(irqStatusReg & irqMaskReg);

   // link field and quantity byte are software loaded; link needs a full word, quantity only byte lane 0
   always_ff @(posedge clk or posedge rst) begin
      if (rst) linkReg <= LINK_RESET;
      else if (wrLink && fullWord) linkReg <= wrData;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) qtyReg <= QTY_RESET;
      else if (wrQty && wrStrb[0]) qtyReg <= {2'b00, wrData[5:0]};
   end

   // axi write channel registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         awHeldReg <= 1'b0;
         wHeldReg <= 1'b0;
         awAddrReg <= 8'h00;
         wDataReg <= 32'h00000000;
         wStrbReg <= 4'h0;
      end else begin
         if (wrGo) awHeldReg <= 1'b0;
         else if (awTake) awHeldReg <= 1'b1;
         if (wrGo) wHeldReg <= 1'b0;
         else if (wTake) wHeldReg <= 1'b1;
         if (awTake) awAddrReg <= s_axi_awaddr;
         if (wTake) begin
            wDataReg <= s_axi_wdata;
            wStrbReg <= s_axi_wstrb;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bValidReg <= 1'b0;
         bRespReg <= 2'b00;
      end else if (wrGo) begin
         bValidReg <= 1'b1;
         bRespReg <= wrKnown ? 2'b00 : 2'b10;
      end else if (s_axi_bready) bValidReg <= 1'b0;
   end

   assign s_axi_awready = !awHeldReg && !bValidReg;
   assign s_axi_wready = !wHeldReg && !bValidReg;
   assign s_axi_bvalid = bValidReg;
   assign s_axi_bresp = bRespReg;

   // read decode
   logic [2*NUM_PARTS-1:0] modesPacked;
   always_comb begin
      for (int i = 0; i < NUM_PARTS; i++) modesPacked[2*i +: 2] = modeReg[i];
   end
   wire logic arTake = s_axi_arvalid && !rValidReg;
   wire logic [31:0] rdState = {12'h000, 2'b00, activePartReg, stateReg};
   wire logic [31:0] linkView = {linkReg[LINK_MORE_BIT], linkReg[LINK_TYPE_LSB +: LINK_TYPE_W],
      linkReg[LINK_SEG_LSB +: LINK_SEG_W], linkReg[LINK_OFS_LSB +: LINK_OFS_W]};
   wire logic [7:0] qtyView = {2'b00, qtyReg[QTY_PLACE_BIT], qtyReg[QTY_DIE_BIT], qtyReg[QTY_N_LSB +: QTY_N_W]};
   logic [31:0] rdMux;
   logic rdOk;
   always_comb begin
      rdOk = 1'b1;
      unique case (s_axi_araddr)
         REG_CMD: rdMux = 32'h00000000;
         REG_STATE: rdMux = rdState;
         REG_MODES: rdMux = 32'(modesPacked);
         REG_IRQ_STATUS: rdMux = 32'(irqStatusReg);
         REG_IRQ_MASK: rdMux = 32'(irqMaskReg);
         REG_DONE: rdMux = 32'h00000000;
         REG_QUERY_LINK, REG_LINK_CFG: rdMux = linkView;
         REG_QUERY_QTY, REG_QTY_CFG: rdMux = 32'(qtyView);
         default: begin
            rdMux = 32'h00000000;
            rdOk = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rValidReg <= 1'b0;
         rDataReg <= 32'h00000000;
         rRespReg <= 2'b00;
      end else if (arTake) begin
         rValidReg <= 1'b1;
         rDataReg <= rdMux;
         rRespReg <= rdOk ? 2'b00 : 2'b10;
      end else if (s_axi_rready) rValidReg <= 1'b0;
   end

   assign s_axi_arready = !rValidReg;
   assign s_axi_rvalid = rValidReg;
   assign s_axi_rdata = rDataReg;
   assign s_axi_rresp = rRespReg;
endmodule : fcsm_top
`default_nettype wire

//--- tb/fcsm_monitor.sv
// axi-side checker for the flash command state machine top.
// assumes one clock domain; bound onto fcsm_top at the foot.
`timescale 1ns/1ps
`default_nettype none
module fcsm_monitor (
   input wire logic clk,
   input wire logic rst,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   logic [7:0] lastAr_reg;
   wire arBad = (lastAr_reg > 8'h24) || (lastAr_reg[1:0] != 2'h0);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) lastAr_reg <= 8'h00;
      else if (s_axi_arvalid && s_axi_arready) lastAr_reg <= s_axi_araddr;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   chk_b_after_wr: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
      else $error("write response missing");
   chk_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   chk_b_drops: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   chk_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken under response");
   chk_r_after_ar: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data missing");
   chk_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data unstable");
   chk_r_drops: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read data repeated");
   chk_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken under data");
   chk_unmapped_err: assert property (s_axi_rvalid && arBad |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   chk_mapped_ok: assert property (s_axi_rvalid && !arBad |-> s_axi_rresp == 2'h0)
      else $error("mapped read refused");
   chk_qty_rsvd: assert property (s_axi_rvalid && lastAr_reg == 8'h1c |-> s_axi_rdata[31:6] == 26'h0)
      else $error("quantity reserved bits set");
endmodule : fcsm_monitor
bind fcsm_top fcsm_monitor mon (.clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

//--- tb/fcsm_host_model.sv
// host side model: axi4-lite master issuing command and register cycles.
// assumes the bench calls its tasks right after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module fcsm_host_model (
   input wire logic clk,
   output logic [7:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   output logic [7:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready
);
   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = 46'h0;
      {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = 11'h0;
   end
   // bounded waits: ok stays low if the slave never answers
   task automatic xwr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp, output logic ok);
      ok = 1'h0;
      resp = 2'h3;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hf;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      for (int n = 0; n < 100 && !ok; n++) begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid) begin
            resp = s_axi_bresp;
            s_axi_bready <= 1'h0;
            ok = 1'h1;
         end
      end
   endtask : xwr
   task automatic xrd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp, output logic ok);
      ok = 1'h0;
      resp = 2'h3;
      d = 32'h0;
      @(posedge clk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      for (int n = 0; n < 100 && !ok; n++) begin
         @(posedge clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid) begin
            d = s_axi_rdata;
            resp = s_axi_rresp;
            s_axi_rready <= 1'h0;
            ok = 1'h1;
         end
      end
   endtask : xrd
endmodule : fcsm_host_model
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench for the flash command state machine top.
// assumes the host model drives the axi bus on one 40 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fail_count++; \
   $display("mismatch at %0t: got %0h exp %0h", $time, (a), (e)); end end
module tb_top
   import fcsm_pkg::*;
;
   typedef struct packed {
      logic dn;
      logic [9:0] c;
      logic [15:0] s;
      logic [2:0] st;
   } fcsm_row_t;
   // done or command write, then expected state and status
   localparam fcsm_row_t ROWS [25] = '{
      '{1'h0, 10'h060, 16'h0002, 3'h0}, '{1'h0, 10'h070, 16'h0001, 3'h4},
      '{1'h0, 10'h060, 16'h0002, 3'h0}, '{1'h0, 10'h0d0, 16'h0001, 3'h1},
      '{1'h0, 10'h0e8, 16'h0020, 3'h0}, '{1'h0, 10'h0d0, 16'h0040, 3'h0},
      '{1'h1, 10'h001, 16'h0001, 3'h1}, '{1'h0, 10'h080, 16'h8000, 3'h0},
      '{1'h0, 10'h0d0, 16'h0040, 3'h0}, '{1'h1, 10'h001, 16'h0001, 3'h1},
      '{1'h0, 10'h050, 16'h0001, 3'h0}, '{1'h0, 10'h020, 16'h0100, 3'h0},
      '{1'h0, 10'h0ff, 16'h0001, 3'h2}, '{1'h0, 10'h020, 16'h0100, 3'h0},
      '{1'h0, 10'h0d0, 16'h0200, 3'h0}, '{1'h1, 10'h001, 16'h0001, 3'h1},
      '{1'h0, 10'h220, 16'h0100, 3'h0}, '{1'h0, 10'h2d0, 16'h0200, 3'h0},
      '{1'h0, 10'h1e8, 16'h0200, 3'h2}, '{1'h0, 10'h2b0, 16'h0400, 3'h0},
      '{1'h0, 10'h240, 16'h0800, 3'h0}, '{1'h0, 10'h210, 16'h1000, 3'h0},
      '{1'h0, 10'h2b0, 16'h2000, 3'h0}, '{1'h0, 10'h2d0, 16'h1000, 3'h0},
      '{1'h1, 10'h001, 16'h0400, 3'h1}};
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic irq, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, ok;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rv;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   int fail_count = 0;
   int checked = 0;
   fcsm_top #(.NUM_PARTS(4)) uut (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);
   fcsm_host_model host (.clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   initial begin
      forever #12.5 clk = ~clk;
   end
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : summarize
   task automatic hang();
      if (ok !== 1'h1) begin
         fail_count++;
         $display("mismatch at %0t: bus timeout", $time);
         summarize();
      end
   endtask : hang
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      host.xwr(a, d, resp, ok);
      hang();
   endtask : wr
   task automatic rd(input logic [7:0] a);
      host.xrd(a, rv, resp, ok);
      hang();
   endtask : rd
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'h0;
      wr(REG_IRQ_MASK, 32'h7);
      foreach (ROWS[i]) begin
         wr(ROWS[i].dn ? REG_DONE : REG_CMD, {22'h0, ROWS[i].c});
         `CHK(irq, |ROWS[i].st)
         rd(REG_STATE);
         `CHK(rv[15:0], ROWS[i].s)
         rd(REG_IRQ_STATUS);
         `CHK(rv[2:0], ROWS[i].st)
         wr(REG_IRQ_STATUS, 32'h7);
         `CHK(irq, 1'h0)
      end
      rd(REG_STATE);
      `CHK(rv[17:0], {2'h2, S_ERS_SUSP})
      // second reset in mid-run, then mode, query and mask checks
      rst <= 1'h1;
      repeat (2) @(posedge clk);
      rst <= 1'h0;
      rd(REG_STATE);
      `CHK(rv[17:0], 18'h00001)
      rd(REG_IRQ_MASK);
      `CHK(rv, 32'h0)
      rd(REG_QUERY_LINK);
      `CHK(rv, LINK_RESET)
      rd(REG_QUERY_QTY);
      `CHK(rv, {24'h0, QTY_RESET})
      wr(REG_CMD, 32'h190);
      wr(REG_CMD, 32'h298);
      wr(REG_CMD, 32'h370);
      rd(REG_MODES);
      `CHK(rv[7:0], 8'he4)
      wr(REG_CMD, 32'h1ff);
      rd(REG_MODES);
      `CHK(rv[7:0], 8'he0)
      rd(REG_STATE);
      `CHK(rv[15:0], 16'h0001)
      `CHK(QRY_LINK_ADDR, 12'h152)
      `CHK(QRY_QTY_ADDR, 12'h156)
      wr(REG_LINK_CFG, {1'h1, 3'h5, 18'h2aaab, 10'h155});
      rd(REG_QUERY_LINK);
      `CHK(rv[9:0], 10'h155)
      `CHK(rv[27:10], 18'h2aaab)
      `CHK(rv[30:28], 3'h5)
      `CHK(rv[31], 1'h1)
      wr(REG_QTY_CFG, 32'hf5);
      rd(REG_QUERY_QTY);
      `CHK(rv, 32'h35)
      `CHK(rv[4], 1'h1)
      wr(REG_QTY_CFG, 32'h05);
      rd(REG_QUERY_QTY);
      `CHK(rv[5:4], 2'h0)
      wr(REG_IRQ_MASK, 32'h0);
      wr(REG_CMD, 32'h060);
      wr(REG_CMD, 32'h070);
      `CHK(irq, 1'h0)
      rd(REG_IRQ_STATUS);
      `CHK(rv[2:0], 3'h4)
      wr(REG_IRQ_MASK, 32'h4);
      `CHK(irq, 1'h1)
      wr(REG_IRQ_STATUS, 32'h4);
      `CHK(irq, 1'h0)
      rd(REG_CMD);
      `CHK(rv, 32'h0)
      wr(8'h40, 32'h1);
      `CHK(resp, 2'h2)
      rd(8'h40);
      `CHK({resp, rv}, 34'h200000000)
      summarize();
   end
endmodule : tb_top
`undef CHK
`default_nettype wire
